// *** rtl/qia_pkg.sv ***
// Package of constants for the quad UART interrupt arbiter.
package qia_pkg;
    localparam int NUM_CH = 4;
    localparam int BID_W = 10;
    localparam int PRIO_W = 7;
    localparam int CH_W = 3;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int BCNT_W = 4;
    localparam int EVT_W = 3;

    localparam logic [7:0] ADDR_THRESHOLD = 8'h80;
    localparam logic [7:0] ADDR_CONTEXT = 8'h84;
    localparam logic [7:0] ADDR_VECTOR = 8'h88;
    localparam logic [7:0] ADDR_UPDATE = 8'h8c;
    localparam logic [7:0] ADDR_CHANNEL = 8'h90;
    localparam logic [7:0] ADDR_TYPE = 8'h94;
    localparam logic [7:0] ADDR_COUNT = 8'h98;
    localparam logic [7:0] ADDR_RXWIN = 8'h9c;
    localparam logic [7:0] ADDR_TXWIN = 8'ha0;
    localparam logic [7:0] ADDR_CONFIG = 8'ha4;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'ha8;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hac;

    localparam logic [1:0] CLS_OTHER = 2'b00;
    localparam logic [1:0] CLS_TX = 2'b01;
    localparam logic [1:0] CLS_RX_ERR = 2'b11;
    localparam logic [1:0] CLS_RX_OK = 2'b10;

    localparam logic [1:0] VEC_PLAIN = 2'b01;
    localparam logic [1:0] VEC_MOD_MIN = 2'b10;

    localparam logic [7:0] CONTEXT_RESET = 8'h00;
    localparam logic [6:0] THRESHOLD_RESET = 7'h00;
    localparam logic [7:0] VECTOR_RESET = 8'h0f;
    localparam logic [1:0] CONFIG_RESET = 2'b01;

    localparam int EV_UPDATE = 0;
    localparam int EV_ACK = 1;
    localparam int EV_REQ = 2;
    localparam int EV_W = 3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD = 3'b010;
endpackage : qia_pkg

// *** rtl/qia_max_bid.sv ***
// Linear compare chain that picks the numerically largest of the masked bids.
`timescale 1ns/10ps
`default_nettype none
module qia_max_bid
    import qia_pkg::*;
(
    input wire logic [qia_pkg::NUM_CH*2*qia_pkg::BID_W-1:0] bids,
    input wire logic [qia_pkg::NUM_CH*2-1:0] valid,
    output logic [qia_pkg::BID_W-1:0] best,
    output logic any
);
    localparam int N = NUM_CH * 2;
    logic [BID_W-1:0] acc [0:N];
    logic [N:0] seen;
    assign acc[0] = '0;
    assign seen[0] = 1'b0;
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_stage
            wire [BID_W-1:0] cand = bids[i*BID_W +: BID_W];
            wire take = valid[i] && (!seen[i] || cand > acc[i]);
            assign acc[i+1] = take ? cand : acc[i];
            assign seen[i+1] = seen[i] | valid[i];
        end
    endgenerate
    assign best = acc[N];
    assign any = seen[N];
endmodule : qia_max_bid
`default_nettype wire

// *** rtl/qia_vector_mux.sv ***
// Forms the vector byte driven during an acknowledge cycle.
`timescale 1ns/10ps
`default_nettype none
module qia_vector_mux
    import qia_pkg::*;
(
    input wire logic [7:0] vector,
    input wire logic [7:0] context_next,
    input wire logic [1:0] vec_ctrl,
    output logic [7:0] vector_out
);
    wire modify = vec_ctrl >= VEC_MOD_MIN;
    // The middle bits carry the class of the new context when modified.
    assign vector_out = modify ? {vector[7:5], context_next[7:6], context_next[2:0]} : vector;
endmodule : qia_vector_mux
`default_nettype wire

// *** rtl/qia_arbiter.sv ***
// Interrupt arbiter with current-context register and global windows over AHB-Lite.
// Notes on behaviour
// [RULE_01] Request only when winner exceeds seven-bit threshold.
// [RULE_02] Below-threshold winner loads context with zeros.
// [RULE_03] Watchdog pending: receivers only, threshold ignored.
// [RULE_04] Bid is priority code then channel.
// [RULE_05] Write to update address reloads context.
// [RULE_06] Acknowledge start loads context, frozen until next.
// [RULE_07] Context bits seven six give class.
// [RULE_08] Other class event code in bits five-three.
// [RULE_09] Receive or transmit class carries fill code.
// [RULE_10] Channel code in context and channel register.
// [RULE_11] Global windows steered by frozen context channel.
// [RULE_12] Control one drives plain vector on acknowledge.
// [RULE_13] Control above one substitutes channel into vector.
// [RULE_14] Type register layout with receiver error inverted.
// [RULE_15] Count register holds characters ready minus one.
// [RULE_16] Receive window returns steered channel's next character.
// [RULE_17] Transmit window writes steered channel's FIFO.
// [RULE_18] Largest bid wins every cycle, channel breaks ties.
`timescale 1ns/10ps
`default_nettype none
module qia_arbiter
    import qia_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [qia_pkg::NUM_CH-1:0] rx_pending,
    input wire logic [qia_pkg::NUM_CH*qia_pkg::PRIO_W-1:0] rx_prio,
    input wire logic [qia_pkg::NUM_CH-1:0] rx_errors,
    input wire logic [qia_pkg::NUM_CH*qia_pkg::BCNT_W-1:0] rx_count,
    input wire logic [qia_pkg::NUM_CH-1:0] tx_pending,
    input wire logic [qia_pkg::NUM_CH*qia_pkg::PRIO_W-1:0] tx_prio,
    input wire logic [qia_pkg::NUM_CH*qia_pkg::BCNT_W-1:0] tx_count,
    input wire logic [qia_pkg::NUM_CH*qia_pkg::PRIO_W-1:0] other_prio,
    input wire logic [qia_pkg::NUM_CH*qia_pkg::EVT_W-1:0] other_event,
    input wire logic watchdog_pending,
    input wire logic host_acknowledge_low,
    output logic [7:0] ack_vector,
    output logic ack_vector_oe,
    output logic host_request_low,
    input wire logic [qia_pkg::NUM_CH*qia_pkg::BYTE_W-1:0] rx_char,
    output logic [qia_pkg::NUM_CH-1:0] rx_pop,
    output logic [qia_pkg::NUM_CH-1:0] tx_push,
    output logic [7:0] tx_char,
    output logic irq
);
    import qia_pkg::*;

    localparam int NB = NUM_CH * 2;

    logic [6:0] threshold_reg;
    logic [7:0] vector_reg;
    logic [1:0] vec_ctrl_reg;
    logic [7:0] context_reg;
    logic [7:0] context_next;
    logic [BCNT_W-1:0] count_reg;
    logic [EV_W-1:0] irq_stat_reg;
    logic [EV_W-1:0] irq_mask_reg;
    logic [1:0] ack_sync_reg;
    logic ack_prev_reg;
    logic req_prev_reg;
    logic [7:0] tx_char_reg;
    logic [NUM_CH-1:0] tx_push_reg;
    logic [NUM_CH-1:0] rx_pop_reg;
    logic [7:0] vec_out_reg;
    logic vec_oe_reg;

    // Address phase capture; a read data phase holds one wait state while the byte is registered.
    logic dp_valid_reg;
    logic dp_write_reg;
    logic [7:0] dp_addr_reg;
    logic [31:0] rdata_reg;

    // Bid candidates: each channel offers its best non-receiver bid and its receiver bid.
    logic [NB*BID_W-1:0] bids;
    logic [NB-1:0] bid_valid;
    logic [BID_W-1:0] win_bid;
    logic win_any;
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            wire [PRIO_W-1:0] rp = rx_prio[c*PRIO_W +: PRIO_W];
            wire [PRIO_W-1:0] tp = tx_prio[c*PRIO_W +: PRIO_W];
            wire [PRIO_W-1:0] op = other_prio[c*PRIO_W +: PRIO_W];
            wire [EVT_W-1:0] oe = other_event[c*EVT_W +: EVT_W];
            wire other_live = oe != '0;
            wire tx_wins = tx_pending[c] && (!other_live || tp >= op);
            wire [PRIO_W-1:0] np = tx_wins ? tp : op;
            wire [CH_W-1:0] chn = CH_W'(c);
            assign bids[(2*c)*BID_W +: BID_W] = {rp, chn}; // RULE_04
            assign bids[(2*c+1)*BID_W +: BID_W] = {np, chn};
            assign bid_valid[2*c] = rx_pending[c];
            // Non-receiver sources are withdrawn while the watchdog is pending.
            assign bid_valid[2*c+1] = (tx_pending[c] || other_live) && !watchdog_pending; // RULE_03
        end
    endgenerate

    qia_max_bid u_max (
        .bids(bids),
        .valid(bid_valid),
        .best(win_bid),
        .any(win_any)
    ); // RULE_18

    wire [CH_W-1:0] win_ch = win_bid[CH_W-1:0];
    wire [PRIO_W-1:0] win_prio = win_bid[BID_W-1:CH_W];
    wire above = win_any && (watchdog_pending || win_prio > threshold_reg); // RULE_01 RULE_03
    wire [1:0] wch = win_ch[1:0];
    wire win_is_rx = rx_pending[wch] && (rx_prio[wch*PRIO_W +: PRIO_W] == win_prio)
                     && !(bid_valid[2*wch+1] && bids[(2*wch+1)*BID_W +: BID_W] > {rx_prio[wch*PRIO_W +: PRIO_W], win_ch});
    wire [EVT_W-1:0] w_evt = other_event[wch*EVT_W +: EVT_W];
    wire w_tx = !win_is_rx && tx_pending[wch] && (w_evt == '0 || tx_prio[wch*PRIO_W +: PRIO_W] >= other_prio[wch*PRIO_W +: PRIO_W]);
    wire [BCNT_W-1:0] w_cnt = win_is_rx ? rx_count[wch*BCNT_W +: BCNT_W] : tx_count[wch*BCNT_W +: BCNT_W];
    wire [1:0] w_cls = win_is_rx ? (rx_errors[wch] ? CLS_RX_ERR : CLS_RX_OK) : (w_tx ? CLS_TX : CLS_OTHER); // RULE_07
    // Nine or fewer characters give code zero; the count input stops at fifteen, so code seven never shows.
    localparam logic [BCNT_W-1:0] FILL_BASE = 4'h9;
    wire [2:0] w_fill = (w_cnt <= FILL_BASE) ? 3'h0 : 3'(w_cnt - FILL_BASE); // RULE_09
    wire [2:0] w_mid = (w_cls == CLS_OTHER) ? w_evt : w_fill; // RULE_08
    assign context_next = above ? {w_cls, w_mid, win_ch} : CONTEXT_RESET; // RULE_02 RULE_10

    // Acknowledge input passes two flops before use.
    wire ack_now = !ack_sync_reg[1];
    wire ack_start = ack_now && !ack_prev_reg;
    wire bus_take = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire wr_dp = dp_valid_reg && dp_write_reg;
    wire rd_dp = dp_valid_reg && !dp_write_reg;
    wire upd_cmd = wr_dp && dp_addr_reg == ADDR_UPDATE; // RULE_05
    wire load_ctx = ack_start || upd_cmd; // RULE_06
    wire [1:0] ctx_ch = context_reg[1:0]; // RULE_11
    wire [EV_W-1:0] ev = {~req_prev_reg & above, ack_start, upd_cmd};
    wire [EV_W-1:0] stat_clr = (wr_dp && dp_addr_reg == ADDR_IRQ_STAT) ? hwdata[EV_W-1:0] : '0;
    wire [7:0] vec_mux;

    qia_vector_mux u_vec (
        .vector(vector_reg),
        .context_next(context_next),
        .vec_ctrl(vec_ctrl_reg),
        .vector_out(vec_mux)
    ); // RULE_13

    wire ctx_rx = context_reg[7];
    wire ctx_tx = !context_reg[7] && context_reg[6];
    // The type register reports receiver error with the polarity opposite the context.
    wire [7:0] type_val = {ctx_rx, ctx_rx & ~context_reg[6], ctx_tx, 2'b00,
                           (ctx_rx || ctx_tx) ? 3'b000 : context_reg[5:3]}; // RULE_14
    wire [7:0] rx_win = rx_char[ctx_ch*BYTE_W +: BYTE_W]; // RULE_16
    wire [7:0] rd_byte =
        (dp_addr_reg == ADDR_THRESHOLD) ? {1'b0, threshold_reg} :
        (dp_addr_reg == ADDR_CONTEXT) ? context_reg :
        (dp_addr_reg == ADDR_VECTOR) ? vector_reg :
        (dp_addr_reg == ADDR_CHANNEL) ? {5'h00, context_reg[2:0]} : // RULE_10
        (dp_addr_reg == ADDR_TYPE) ? type_val :
        (dp_addr_reg == ADDR_COUNT) ? {4'h0, count_reg} : // RULE_15
        (dp_addr_reg == ADDR_RXWIN) ? rx_win :
        (dp_addr_reg == ADDR_CONFIG) ? {5'h00, vec_ctrl_reg, 1'b0} :
        (dp_addr_reg == ADDR_IRQ_STAT) ? {5'h00, irq_stat_reg} :
        (dp_addr_reg == ADDR_IRQ_MASK) ? {5'h00, irq_mask_reg} : 8'h00;

    assign hreadyout = !rd_dp;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign host_request_low = ~req_prev_reg; // RULE_01
    assign ack_vector = vec_out_reg;
    assign ack_vector_oe = vec_oe_reg;
    assign tx_char = tx_char_reg;
    assign tx_push = tx_push_reg;
    assign rx_pop = rx_pop_reg;
    assign irq = |(irq_stat_reg & irq_mask_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
        end else begin
            dp_valid_reg <= bus_take && hsize == HSIZE_WORD;
            dp_write_reg <= hwrite;
            dp_addr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            threshold_reg <= THRESHOLD_RESET;
            vector_reg <= VECTOR_RESET;
            vec_ctrl_reg <= CONFIG_RESET;
            irq_mask_reg <= '0;
        end else if (wr_dp) begin
            if (dp_addr_reg == ADDR_THRESHOLD) threshold_reg <= hwdata[6:0];
            if (dp_addr_reg == ADDR_VECTOR) vector_reg <= hwdata[7:0];
            if (dp_addr_reg == ADDR_CONFIG) vec_ctrl_reg <= hwdata[2:1];
            if (dp_addr_reg == ADDR_IRQ_MASK) irq_mask_reg <= hwdata[EV_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            context_reg <= CONTEXT_RESET;
            count_reg <= '0;
        end else if (load_ctx) begin
            context_reg <= context_next; // RULE_06
            // Count minus one; a zero count still reads as code zero.
            count_reg <= (w_cnt == '0) ? '0 : w_cnt - 4'h1; // RULE_15
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_sync_reg <= 2'b11;
            ack_prev_reg <= 1'b0;
            req_prev_reg <= 1'b0;
            irq_stat_reg <= '0;
            vec_out_reg <= 8'h00;
            vec_oe_reg <= 1'b0;
        end else begin
            ack_sync_reg <= {ack_sync_reg[0], host_acknowledge_low};
            ack_prev_reg <= ack_now;
            req_prev_reg <= above; // RULE_01
            irq_stat_reg <= (irq_stat_reg & ~stat_clr) | ev;
            if (ack_start) vec_out_reg <= (vec_ctrl_reg == VEC_PLAIN) ? vector_reg : vec_mux; // RULE_12 RULE_13
            vec_oe_reg <= ack_now && vec_ctrl_reg != 2'b00;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= '0;
            tx_char_reg <= 8'h00;
            tx_push_reg <= '0;
            rx_pop_reg <= '0;
        end else begin
            rdata_reg <= rd_dp ? {24'h000000, rd_byte} : 32'h0;
            tx_push_reg <= '0;
            rx_pop_reg <= '0;
            if (wr_dp && dp_addr_reg == ADDR_TXWIN) begin
                tx_char_reg <= hwdata[7:0];
                tx_push_reg[ctx_ch] <= 1'b1; // RULE_17
            end
            if (rd_dp && dp_addr_reg == ADDR_RXWIN) rx_pop_reg[ctx_ch] <= 1'b1; // RULE_16
        end
    end

    property p_req_thresh;
        @(posedge hclk) disable iff (!hresetn)
        (above && !watchdog_pending) |-> ##1 (!host_request_low && $past(win_prio) > $past(threshold_reg));
    endproperty
    a_req_thresh: assert property (p_req_thresh) else $error("request without winner above threshold"); // RULE_01

    property p_zero_ctx;
        @(posedge hclk) disable iff (!hresetn)
        (load_ctx && !above) |=> context_reg == CONTEXT_RESET;
    endproperty
    a_zero_ctx: assert property (p_zero_ctx) else $error("context not zero below threshold"); // RULE_02

    property p_frozen;
        @(posedge hclk) disable iff (!hresetn)
        !load_ctx |=> $stable(context_reg);
    endproperty
    a_frozen: assert property (p_frozen) else $error("context changed without load"); // RULE_06

    property p_update;
        @(posedge hclk) disable iff (!hresetn)
        upd_cmd |=> context_reg == $past(context_next);
    endproperty
    a_update: assert property (p_update) else $error("update command did not load context"); // RULE_05

    property p_rx_class;
        @(posedge hclk) disable iff (!hresetn)
        (watchdog_pending && load_ctx && above) |=> context_reg[7];
    endproperty
    a_rx_class: assert property (p_rx_class) else $error("non receiver won during watchdog"); // RULE_03

    property p_chan;
        @(posedge hclk) disable iff (!hresetn)
        (load_ctx && above) |=> context_reg[2:0] == $past(win_bid[CH_W-1:0]);
    endproperty
    a_chan: assert property (p_chan) else $error("context channel wrong"); // RULE_10

    sequence s_ack_plain;
        ack_start && vec_ctrl_reg == VEC_PLAIN;
    endsequence
    property p_vec_plain;
        @(posedge hclk) disable iff (!hresetn)
        s_ack_plain |=> ack_vector == $past(vector_reg);
    endproperty
    a_vec_plain: assert property (p_vec_plain) else $error("plain vector altered"); // RULE_12

    property p_tx_push;
        @(posedge hclk) disable iff (!hresetn)
        (wr_dp && dp_addr_reg == ADDR_TXWIN) |=> tx_push == (4'b0001 << $past(ctx_ch));
    endproperty
    a_tx_push: assert property (p_tx_push) else $error("transmit window steered wrongly"); // RULE_17

    property p_req_low;
        @(posedge hclk) disable iff (!hresetn)
        !above |=> host_request_low;
    endproperty
    a_req_low: assert property (p_req_low) else $error("request without winner"); // RULE_01

    property p_ack_load;
        @(posedge hclk) disable iff (!hresetn)
        ack_start |=> context_reg == $past(context_next);
    endproperty
    a_ack_load: assert property (p_ack_load) else $error("acknowledge did not load context"); // RULE_06

    sequence s_ack_mod;
        ack_start && vec_ctrl_reg >= VEC_MOD_MIN;
    endsequence
    property p_vec_mod;
        @(posedge hclk) disable iff (!hresetn)
        s_ack_mod |=> ack_vector[7:5] == $past(vector_reg[7:5]) && ack_vector[2:0] == $past(context_next[2:0]);
    endproperty
    a_vec_mod: assert property (p_vec_mod) else $error("modified vector wrong"); // RULE_13

    property p_rx_pop;
        @(posedge hclk) disable iff (!hresetn)
        (rd_dp && dp_addr_reg == ADDR_RXWIN) |=> rx_pop == (4'b0001 << $past(ctx_ch));
    endproperty
    a_rx_pop: assert property (p_rx_pop) else $error("receive window steered wrongly"); // RULE_16

    property p_fill_low;
        @(posedge hclk) disable iff (!hresetn)
        (load_ctx && above && w_cls != CLS_OTHER && w_cnt <= FILL_BASE) |=> context_reg[5:3] == 3'b000;
    endproperty
    a_fill_low: assert property (p_fill_low) else $error("fill code not zero"); // RULE_09

    property p_count;
        @(posedge hclk) disable iff (!hresetn)
        (load_ctx && w_cnt != '0) |=> count_reg == $past(w_cnt) - 4'h1;
    endproperty
    a_count: assert property (p_count) else $error("count not one less"); // RULE_15

    property p_rd_wait;
        @(posedge hclk) disable iff (!hresetn)
        rd_dp |-> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong"); // read data phase holds one wait state
endmodule : qia_arbiter
`default_nettype wire

// *** testbench/qia_host_model.sv ***
// Host processor model that runs interrupt acknowledge cycles.
`timescale 1ns/10ps
`default_nettype none
module qia_host_model (
    input wire logic hclk,
    input wire logic host_request_low,
    input wire logic [7:0] ack_vector,
    input wire logic ack_vector_oe,
    output logic host_acknowledge_low
);
    initial host_acknowledge_low = 1'b1;

    // The host waits at most 16 cycles for a request and then acknowledges anyway; every wait is bounded.
    task automatic ack_cycle(output logic [7:0] v);
        int n;
        v = 8'hxx;
        n = 0;
        while (host_request_low !== 1'b0 && n < 16) begin
            @(posedge hclk);
            n++;
        end
        host_acknowledge_low <= 1'b0;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (ack_vector_oe !== 1'b1 && n < 16);
        if (ack_vector_oe === 1'b1) begin
            v = ack_vector;
        end
        host_acknowledge_low <= 1'b1;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (ack_vector_oe !== 1'b0 && n < 16);
    endtask : ack_cycle
endmodule : qia_host_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the interrupt arbiter and its host model.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import qia_pkg::*;
    typedef struct packed {
        logic [1:0] k;
        logic [1:0] ch;
        logic [6:0] pr;
        logic [3:0] v;
        logic [6:0] th;
        logic [7:0] ctx;
    } qia_row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = '0;
    wire hreadyout, hresp, ack_vector_oe, host_request_low, host_acknowledge_low, irq;
    wire [31:0] hrdata;
    wire [7:0] ack_vector, tx_char;
    wire [3:0] rx_pop, tx_push;
    logic [3:0] rx_pending = '0, rx_errors = '0, tx_pending = '0;
    logic [27:0] rx_prio = '0, tx_prio = '0, other_prio = '0;
    logic [15:0] rx_count = '0, tx_count = '0;
    logic [11:0] other_event = '0;
    logic watchdog_pending = 1'b0;
    logic [31:0] rx_char = 32'hd4c3b2a1;
    logic [31:0] pop_cnt = '0, push_cnt = '0, exp_pop = '0, exp_push = '0, q;
    logic [7:0] tx_seen = '0, v;
    int error_cnt = 0, checks_done = 0;
    // Kind 0 other, 1 transmitter, 2 receiver, 3 receiver with errors.
    qia_row_t rows [0:9] = '{
        '{2'd0, 2'd0, 7'h20, 4'd1, 7'h10, 8'h08}, '{2'd0, 2'd1, 7'h21, 4'd2, 7'h10, 8'h11},
        '{2'd0, 2'd2, 7'h22, 4'd3, 7'h10, 8'h1a}, '{2'd0, 2'd3, 7'h23, 4'd5, 7'h10, 8'h2b},
        '{2'd1, 2'd1, 7'h31, 4'd5, 7'h30, 8'h41}, '{2'd1, 2'd2, 7'h7f, 4'd15, 7'h7e, 8'h72},
        '{2'd2, 2'd3, 7'h40, 4'd12, 7'h00, 8'h9b}, '{2'd3, 2'd0, 7'h41, 4'd9, 7'h3f, 8'hc0},
        '{2'd2, 2'd2, 7'h50, 4'd0, 7'h20, 8'h82}, '{2'd1, 2'd0, 7'h2f, 4'd4, 7'h30, 8'h00}};

    qia_arbiter qia_arbiter_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_pending, .rx_prio, .rx_errors, .rx_count,
        .tx_pending, .tx_prio, .tx_count, .other_prio, .other_event, .watchdog_pending,
        .host_acknowledge_low, .ack_vector, .ack_vector_oe, .host_request_low, .rx_char, .rx_pop,
        .tx_push, .tx_char, .irq);
    qia_host_model qia_host_model_inst (.hclk, .host_request_low, .ack_vector, .ack_vector_oe,
        .host_acknowledge_low);

    initial begin
        forever #4 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        for (int c = 0; c < 4; c++) begin
            if (rx_pop[c] === 1'b1) pop_cnt[c*8+:8] <= pop_cnt[c*8+:8] + 8'h1;
            if (tx_push[c] === 1'b1) push_cnt[c*8+:8] <= push_cnt[c*8+:8] + 8'h1;
        end
        if (tx_push !== 4'h0) tx_seen <= tx_char;
    end

    task automatic end_sim;
        if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rd_chk

    // One source of the given kind on one channel; other fields repeat the same priority.
    task automatic set_src(input logic [1:0] k, input logic [1:0] ch, input logic [6:0] pr, input logic [3:0] n);
        logic [3:0] rp, re, tp;
        logic [11:0] ev;
        rp = '0;
        re = '0;
        tp = '0;
        ev = '0;
        rp[ch] = k[1];
        re[ch] = (k == 2'd3);
        tp[ch] = (k == 2'd1);
        if (k == 2'd0) ev[ch*3+:3] = n[2:0];
        rx_pending <= rp;
        rx_errors <= re;
        tx_pending <= tp;
        other_event <= ev;
        rx_prio <= {4{pr}};
        tx_prio <= {4{pr}};
        other_prio <= {4{pr}};
        rx_count <= {4{n}};
        tx_count <= {4{n}};
    endtask : set_src

    function automatic logic [7:0] typ(input qia_row_t r);
        case (r.k)
            2'd0: typ = {5'h0, r.v[2:0]};
            2'd1: typ = 8'h20;
            2'd2: typ = 8'hc0;
            default: typ = 8'h80;
        endcase
    endfunction : typ

    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        end_sim();
    end

    initial begin
        qia_row_t r;
        int i;
        repeat (8) @(posedge hclk);
        chk({31'h0, host_request_low}, 32'h1);
        hresetn <= 1'b1;
        rd_chk(ADDR_CONTEXT, 32'h0);
        rd_chk(ADDR_VECTOR, 32'h0f);
        rd_chk(ADDR_CONFIG, 32'h2);
        chk({31'h0, hresp}, 32'h0);
        wr(8'hfc, 32'hff);
        rd_chk(8'hfc, 32'h0);
        wr(ADDR_THRESHOLD, 32'hff);
        rd_chk(ADDR_THRESHOLD, 32'h7f);
        for (i = 0; i < 10; i++) begin
            r = rows[i];
            set_src(r.k, r.ch, r.pr, r.v);
            wr(ADDR_THRESHOLD, {25'h0, r.th});
            repeat (3) @(posedge hclk);
            chk({31'h0, host_request_low}, {31'h0, r.pr <= r.th});
            wr(ADDR_UPDATE, 32'hdeadbeef);
            rd_chk(ADDR_CONTEXT, {24'h0, r.ctx});
            if (r.ctx != 8'h00) begin
                rd_chk(ADDR_CHANNEL, {30'h0, r.ch});
                rd_chk(ADDR_TYPE, {24'h0, typ(r)});
            end
            if (r.k != 2'd0 && r.ctx != 8'h00) rd_chk(ADDR_COUNT, {28'h0, (r.v == 4'h0) ? 4'h0 : r.v - 4'h1});
            if (r.k[1]) begin
                rd_chk(ADDR_RXWIN, {24'h0, rx_char[r.ch*8+:8]});
                exp_pop[r.ch*8+:8] += 8'h1;
            end
            if (r.k == 2'd1 && r.ctx != 8'h00) begin
                wr(ADDR_TXWIN, 32'h5c);
                exp_push[r.ch*8+:8] += 8'h1;
            end
            repeat (2) @(posedge hclk);
            chk(pop_cnt, exp_pop);
            chk(push_cnt, exp_push);
        end
        chk({24'h0, tx_seen}, 32'h5c);
        set_src(2'd1, 2'd0, 7'h30, 4'd4);
        wr(ADDR_THRESHOLD, 32'h30);
        repeat (3) @(posedge hclk);
        chk({31'h0, host_request_low}, 32'h1);
        set_src(2'd1, 2'd1, 7'h60, 4'd2);
        @(posedge hclk);
        tx_pending <= 4'b1010;
        wr(ADDR_THRESHOLD, 32'h10);
        wr(ADDR_UPDATE, 32'h0);
        rd_chk(ADDR_CONTEXT, 32'h43);
        set_src(2'd2, 2'd1, 7'h05, 4'd3);
        @(posedge hclk);
        tx_pending <= 4'b0100;
        watchdog_pending <= 1'b1;
        wr(ADDR_THRESHOLD, 32'h7f);
        repeat (3) @(posedge hclk);
        chk({31'h0, host_request_low}, 32'h0);
        wr(ADDR_UPDATE, 32'h0);
        rd_chk(ADDR_CONTEXT, 32'h81);
        watchdog_pending <= 1'b0;
        set_src(2'd3, 2'd1, 7'h40, 4'd10);
        wr(ADDR_THRESHOLD, 32'h10);
        wr(ADDR_VECTOR, 32'ha5);
        wr(ADDR_IRQ_STAT, 32'h7);
        qia_host_model_inst.ack_cycle(v);
        chk({24'h0, v}, 32'ha5);
        rd_chk(ADDR_CONTEXT, 32'hc9);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0, q);
        chk(q & 32'h2, 32'h2);
        set_src(2'd1, 2'd2, 7'h50, 4'd3);
        repeat (3) @(posedge hclk);
        rd_chk(ADDR_CONTEXT, 32'hc9);
        rd_chk(ADDR_CHANNEL, 32'h1);
        for (i = 2; i < 4; i++) begin
            wr(ADDR_CONFIG, {29'h0, i[1:0], 1'b0});
            qia_host_model_inst.ack_cycle(v);
            chk({24'h0, v}, 32'haa);
        end
        rd_chk(ADDR_CONTEXT, 32'h42);
        wr(ADDR_IRQ_STAT, 32'h7);
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_UPDATE, 32'h0);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0, q);
        chk(q & 32'h1, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h1);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        wr(ADDR_IRQ_STAT, 32'h1);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
